// ### ref_rank_bw_ctrl.sv
// Reference ranking, selection masks and filter bandwidth source with APB registers
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module ref_rank_bw_ctrl #(
  parameter int EVAL_CYCLES = ref_rank_pkg::EVAL_PERIOD
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ref_qualified,
  input wire logic [1:0] ref_sel_pins,
  input wire logic [5:0] other_ranks,
  input wire logic bandwidth_pin,
  input wire logic divider_sync,
  input wire logic lock_detect,
  input wire logic sm_wants_tracking,
  input wire ref_rank_pkg::bw_settings_t bw_settings,
  output logic [1:0] selected_ref,
  output logic ref_valid,
  output logic [3:0] ref_invalid_sts,
  output logic locked,
  output logic [2:0] bw_shift,
  output logic [4:0] bw_mult,
  output logic irq
);
  ref_rank_pkg::rank_mask_t rank_mask_r;
  ref_rank_pkg::mode_t mode_r;
  ref_rank_pkg::select_cfg_t sel_cfg_r;
  ref_rank_pkg::sel_state_t state_r;
  ref_rank_pkg::sel_state_t state_nxt;
  logic [1:0] selected_r;
  logic valid_r;
  logic locked_r;
  logic [3:0] invalid_r;
  logic [2:0] shift_r;
  logic [4:0] mult_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_mask_r;
  logic [7:0] eval_cnt_r;
  logic [1:0] best_ref;
  logic best_found;
  logic [1:0] rev_ref;
  logic rev_found;
  logic [1:0] next_ref;
  logic next_found;
  logic [1:0] pick_ref;
  logic pick_valid;

  // Decoded bus access, completes in the access phase with no wait state
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_rank = (paddr == ref_rank_pkg::RANK_MASK_OFFSET);
  wire hit_mode = (paddr == ref_rank_pkg::MODE_OFFSET);
  wire hit_sel = (paddr == ref_rank_pkg::SELECT_OFFSET);
  wire hit_stat = (paddr == ref_rank_pkg::STATUS_OFFSET);
  wire hit_irqs = (paddr == ref_rank_pkg::IRQ_STATUS_OFFSET);
  wire hit_irqm = (paddr == ref_rank_pkg::IRQ_MASK_OFFSET);
  wire mapped = hit_rank | hit_mode | hit_sel | hit_stat | hit_irqs | hit_irqm;
  wire eval_tick = (eval_cnt_r == 8'(EVAL_CYCLES - 1));

  // Rank table: reference 0 from this register, others from the other_ranks input
  wire [7:0] ranks = {other_ranks, rank_mask_r.rank};

  // qualify unmasked refs; masked refs never candidates
  wire [3:0] eligible = ref_qualified & ~rank_mask_r.select_mask;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign selected_ref = selected_r;
  assign ref_valid = valid_r;
  assign ref_invalid_sts = invalid_r;
  assign locked = locked_r;
  assign bw_shift = shift_r;
  assign bw_mult = mult_r;
  assign irq = |(irq_status_r & irq_mask_r);

  // lowest number wins ties; strict compare keeps earlier
  always_comb begin
    best_ref = 2'h0;
    best_found = 1'b0;
    for (int i = 0; i < ref_rank_pkg::NUM_REFS; i++) begin
      if (eligible[i] && (!best_found || ranks[2*i +: 2] < ranks[2*best_ref +: 2])) begin
        best_ref = 2'(i);
        best_found = 1'b1;
      end
    end
  end

  // equal rank never beats the current reference
  always_comb begin
    rev_ref = selected_r;
    rev_found = 1'b0;
    for (int i = 0; i < ref_rank_pkg::NUM_REFS; i++) begin
      if (eligible[i] && ranks[2*i +: 2] < ranks[2*rev_ref +: 2]) begin
        rev_ref = 2'(i);
        rev_found = 1'b1;
      end
    end
  end

  // selection source; reserved mode keeps the current choice
  always_comb begin
    pick_ref = selected_r;
    pick_valid = valid_r;
    case (sel_cfg_r.selection_mode)
      ref_rank_pkg::SEL_MODE_MANUAL: begin
        pick_ref = sel_cfg_r.manual_ref;
        pick_valid = eligible[sel_cfg_r.manual_ref];
      end
      ref_rank_pkg::SEL_MODE_PINS: begin
        pick_ref = ref_sel_pins;
        pick_valid = eligible[ref_sel_pins];
      end
      ref_rank_pkg::SEL_MODE_AUTO: begin
        pick_ref = next_ref;
        pick_valid = next_found;
      end
      default: begin
        pick_ref = selected_r;
        pick_valid = valid_r && eligible[selected_r];
      end
    endcase
  end

  // tie-break by number on the initial choice and on fallback after losing the current reference
  always_comb begin
    state_nxt = state_r;
    next_ref = selected_r;
    next_found = valid_r;
    case (state_r)
      ref_rank_pkg::SEL_IDLE: begin
        state_nxt = ref_rank_pkg::SEL_INITIAL;
      end
      ref_rank_pkg::SEL_INITIAL: begin
        next_ref = best_ref;
        next_found = best_found;
        if (best_found) begin
          state_nxt = ref_rank_pkg::SEL_HOLDING;
        end
      end
      ref_rank_pkg::SEL_HOLDING: begin
        if (!eligible[selected_r]) begin
          // Current lost: fall back to best remaining, or restart
          next_ref = best_ref;
          next_found = best_found;
          if (!best_found) begin
            state_nxt = ref_rank_pkg::SEL_INITIAL;
          end
        end else if (sel_cfg_r.revertive_en && rev_found) begin
          // revertive moves only to strictly better rank
          next_ref = rev_ref;
          next_found = 1'b1;
        end
      end
      default: begin
        state_nxt = ref_rank_pkg::SEL_IDLE;
      end
    endcase
  end

  // Registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rank_mask_r <= ref_rank_pkg::RANK_MASK_RESET[5:0];
      // relock set, bandwidth by state machine
      mode_r <= ref_rank_pkg::MODE_RESET[15:12];
      sel_cfg_r <= '0;
      irq_mask_r <= '0;
    end else if (wr) begin
      if (hit_rank) begin
        rank_mask_r <= pwdata[5:0] & ref_rank_pkg::RANK_MASK_WRITABLE;
      end
      if (hit_mode) begin
        mode_r <= pwdata[15:12];
      end
      if (hit_sel) begin
        sel_cfg_r <= pwdata[4:0];
      end
      if (hit_irqm) begin
        irq_mask_r <= pwdata[2:0];
      end
    end
  end

  // Evaluation tick keeps switching at a steady, glitch-free pace
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_cnt_r <= '0;
    end else begin
      eval_cnt_r <= eval_tick ? 8'h00 : eval_cnt_r + 8'h01;
    end
  end

  // selection only changes on the evaluation tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ref_rank_pkg::SEL_IDLE;
      selected_r <= 2'h0;
      valid_r <= 1'b0;
    end else if (eval_tick) begin
      if (sel_cfg_r.selection_mode == ref_rank_pkg::SEL_MODE_AUTO) begin
        state_r <= state_nxt;
      end else begin
        state_r <= ref_rank_pkg::SEL_INITIAL;
      end
      selected_r <= pick_ref;
      valid_r <= pick_valid;
    end else if (!eligible[selected_r]) begin
      // a masked current reference is dropped at once
      valid_r <= 1'b0;
    end
  end

  // masked refs flag invalid regardless of monitors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalid_r <= 4'hF;
    end else begin
      invalid_r <= ~ref_qualified | rank_mask_r.select_mask;
    end
  end

  // divider sync drops lock while relock set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_r <= 1'b0;
    end else if (divider_sync && mode_r.relock_on_resync) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= lock_detect && valid_r;
    end
  end

  // Bandwidth source: high picks tracking settings
  wire use_tracking =
    (mode_r.bandwidth_source_select == ref_rank_pkg::BW_SRC_STATE_MACHINE) ? sm_wants_tracking :
    (mode_r.bandwidth_source_select == ref_rank_pkg::BW_SRC_PIN) ? bandwidth_pin :
    (mode_r.bandwidth_source_select == ref_rank_pkg::BW_SRC_MANUAL) ?
      mode_r.manual_bandwidth_choice :
    // reserved value falls back to state machine
    sm_wants_tracking;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= '0;
      mult_r <= '0;
    end else if (use_tracking) begin
      shift_r <= bw_settings.tracking_bandwidth_shift;
      mult_r <= bw_settings.tracking_bandwidth_multiplier;
    end else begin
      shift_r <= bw_settings.locking_bandwidth_shift;
      mult_r <= bw_settings.locking_bandwidth_multiplier;
    end
  end

  // Sticky events; a set in the clearing cycle wins
  wire [2:0] irq_set = {locked_r & ~(lock_detect & valid_r) | (locked_r & divider_sync &
    mode_r.relock_on_resync), valid_r & ~eligible[selected_r],
    eval_tick & (pick_ref != selected_r) & pick_valid};
  wire [2:0] irq_clr = (wr && hit_irqs) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end
  end

  // Read mux; bit 11 and unused bits read zero
  wire [31:0] mode_rd = {16'h0000, mode_r, 12'h000};
  wire [31:0] rank_rd = {26'h0000000, rank_mask_r};
  wire [31:0] sel_rd = {27'h0000000, sel_cfg_r};
  wire [31:0] stat_rd = {22'h000000, locked_r, valid_r, selected_r, 2'h0, invalid_r};
  wire [31:0] rd_mux = hit_rank ? rank_rd : hit_mode ? mode_rd : hit_sel ? sel_rd :
    hit_stat ? stat_rd : hit_irqs ? {29'h00000000, irq_status_r} :
    hit_irqm ? {29'h00000000, irq_mask_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
endmodule : ref_rank_bw_ctrl

// ### ref_rank_pkg.sv
// Constants, register layouts and carriers for reference ranking and bandwidth mode
package ref_rank_pkg;
  localparam int NUM_REFS = 4;
  localparam logic [11:0] RANK_MASK_OFFSET = 12'h000;
  localparam logic [11:0] MODE_OFFSET = 12'h004;
  localparam logic [11:0] SELECT_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h010;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h014;
  localparam int RANK0_LSB = 4;
  localparam int RELOCK_BIT = 15;
  localparam int MANUAL_BW_BIT = 14;
  localparam int BW_SRC_LSB = 12;
  localparam logic [15:0] RANK_MASK_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h8000;
  localparam logic [15:0] MODE_WRITABLE = 16'hF000;
  localparam logic [5:0] RANK_MASK_WRITABLE = 6'h3F;
  localparam logic [1:0] BW_SRC_STATE_MACHINE = 2'h0;
  localparam logic [1:0] BW_SRC_PIN = 2'h1;
  localparam logic [1:0] BW_SRC_MANUAL = 2'h3;
  localparam logic [1:0] SEL_MODE_MANUAL = 2'h0;
  localparam logic [1:0] SEL_MODE_PINS = 2'h1;
  localparam logic [1:0] SEL_MODE_AUTO = 2'h2;
  localparam int EVAL_PERIOD = 16;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_UNLOCK = 2;

  typedef struct packed {
    logic [1:0] rank;
    logic [3:0] select_mask;
  } rank_mask_t;

  typedef struct packed {
    logic relock_on_resync;
    logic manual_bandwidth_choice;
    logic [1:0] bandwidth_source_select;
  } mode_t;

  typedef struct packed {
    logic [1:0] selection_mode;
    logic revertive_en;
    logic [1:0] manual_ref;
  } select_cfg_t;

  typedef struct packed {
    logic [2:0] locking_bandwidth_shift;
    logic [4:0] locking_bandwidth_multiplier;
    logic [2:0] tracking_bandwidth_shift;
    logic [4:0] tracking_bandwidth_multiplier;
  } bw_settings_t;

  typedef enum logic [2:0] {
    SEL_IDLE = 3'b001,
    SEL_INITIAL = 3'b010,
    SEL_HOLDING = 3'b100
  } sel_state_t;
endpackage : ref_rank_pkg

// ### ref_monitor_model.sv
// Reference monitor model: qualifies each reference once its signal has been steady
`timescale 1ns/10ps
module ref_monitor_model #(
  parameter int QUAL_CYCLES = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] ref_present,
  output logic [3:0] ref_qualified
);
  logic [3:0][3:0] steady_r;
  // Loss shows at once, qualification waits out a steady run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steady_r <= '0;
      ref_qualified <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        steady_r[i] <= !ref_present[i] ? 4'h0 : (steady_r[i] == 4'hF) ? 4'hF : steady_r[i] + 4'h1;
        ref_qualified[i] <= ref_present[i] && (steady_r[i] >= 4'(QUAL_CYCLES));
      end
    end
  end
endmodule : ref_monitor_model

// ### ref_rank_bw_asserts.sv
// Concurrent checks on reference selection, masks, relock and bandwidth source
`timescale 1ns/10ps
module ref_rank_bw_asserts #(
  parameter int EVAL_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] ref_qualified,
  input wire logic bandwidth_pin,
  input wire logic divider_sync,
  input wire logic lock_detect,
  input wire logic sm_wants_tracking,
  input wire ref_rank_pkg::bw_settings_t bw_settings,
  input wire logic [1:0] selected_ref,
  input wire logic ref_valid,
  input wire logic [3:0] ref_invalid_sts,
  input wire logic locked,
  input wire logic [2:0] bw_shift,
  input wire logic [4:0] bw_mult
);
  logic [3:0] mode_r;
  logic [3:0] mask_r;
  logic [1:0] sel_prev_r;
  logic [7:0] gap_r;
  wire logic wr_en = psel && penable && pwrite;
  wire logic moved = selected_ref != sel_prev_r;
  wire logic pick = (mode_r[1:0] == 2'h3) ? mode_r[2] :
    (mode_r[1:0] == 2'h1) ? bandwidth_pin : sm_wants_tracking;
  wire logic [7:0] bw_want = pick ? bw_settings[7:0] : bw_settings[15:8];
  wire logic [7:0] bw_out = {bw_shift, bw_mult};
  wire logic bad_cur = ref_valid && (mask_r[selected_ref] || !ref_qualified[selected_ref]);
  // Mirrors of written fields, since the checker sees only ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 4'h8;
      mask_r <= 4'h0;
      sel_prev_r <= 2'h0;
      gap_r <= 8'hFF;
    end else begin
      if (wr_en && paddr == 12'h004) mode_r <= pwdata[15:12];
      if (wr_en && paddr == 12'h000) mask_r <= pwdata[3:0];
      sel_prev_r <= selected_ref;
      gap_r <= moved ? 8'h00 : (gap_r == 8'hFF) ? 8'hFF : gap_r + 8'h01;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  relock_drop_a: assert property (mode_r[3] && divider_sync |=> !locked)
    else $error("lock held across divider sync");
  lock_follow_a: assert property (locked |-> $past(lock_detect && ref_valid))
    else $error("lock without detect and valid reference");
  bw_machine_a: assert property (mode_r[1:0] == 2'h0 |=> bw_out == $past(bw_want))
    else $error("state machine bandwidth choice not applied");
  bw_pin_a: assert property (mode_r[1:0] == 2'h1 |=> bw_out == $past(bw_want))
    else $error("pin bandwidth choice not applied");
  bw_manual_a: assert property (mode_r[1:0] == 2'h3 |=> bw_out == $past(bw_want))
    else $error("manual bandwidth choice not applied");
  mask_invalid_a: assert property (|mask_r |=> (ref_invalid_sts & $past(mask_r)) == $past(mask_r))
    else $error("masked reference not flagged invalid");
  bad_ref_a: assert property (bad_cur |=> !bad_cur)
    else $error("ineligible reference kept valid");
  reserved_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h004 |-> prdata[11:0] == 12'h000)
    else $error("reserved mode bits read nonzero");
  tick_spacing_a: assert property (moved |-> gap_r >= EVAL_CYCLES - 1)
    else $error("selection changed between evaluations");
  sync_drop_c: cover property (mode_r[3] && divider_sync && locked);
  moved_c: cover property (moved && ref_valid);
  masked_c: cover property (|mask_r && ref_valid);
endmodule : ref_rank_bw_asserts

// ### tb_dpll_ref_priority_bw_mode.sv
// Self-checking bench for reference ranking, masks, relock and bandwidth source
`timescale 1ns/10ps
module tb_dpll_ref_priority_bw_mode;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, c;
  logic bandwidth_pin, divider_sync, lock_detect, sm_wants_tracking, ref_valid, locked, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ref_qualified, ref_present, ref_invalid_sts;
  logic [1:0] ref_sel_pins, selected_ref, src;
  logic [5:0] other_ranks;
  logic [2:0] bw_shift;
  logic [4:0] bw_mult;
  ref_rank_pkg::bw_settings_t bw_settings;
  int error_cnt, checked, cyc;
  logic [31:0] sel_v [3] = '{32'h08, 32'h00, 32'h18};
  logic [31:0] sts_v [3] = '{32'h182, 32'h102, 32'h102};
  ref_rank_bw_ctrl #(.EVAL_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_qualified(ref_qualified),
    .ref_sel_pins(ref_sel_pins), .other_ranks(other_ranks), .bandwidth_pin(bandwidth_pin),
    .divider_sync(divider_sync), .lock_detect(lock_detect),
    .sm_wants_tracking(sm_wants_tracking), .bw_settings(bw_settings),
    .selected_ref(selected_ref), .ref_valid(ref_valid), .ref_invalid_sts(ref_invalid_sts),
    .locked(locked), .bw_shift(bw_shift), .bw_mult(bw_mult), .irq(irq));
  ref_monitor_model #(.QUAL_CYCLES(3)) mon (.pclk(pclk), .presetn(presetn),
    .ref_present(ref_present), .ref_qualified(ref_qualified));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task settle;
    repeat (12) @(posedge pclk);
  endtask : settle
  task sync_chk(input logic exp);
    divider_sync <= 1'b1;
    @(posedge pclk);
    divider_sync <= 1'b0;
    @(negedge pclk);
    check({31'h0, locked}, {31'h0, exp});
    @(posedge pclk);
  endtask : sync_chk
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ref_present = 4'h0;
    ref_sel_pins = 2'h2;
    other_ranks = 6'h00;
    bandwidth_pin = 1'b0;
    divider_sync = 1'b0;
    lock_detect = 1'b0;
    sm_wants_tracking = 1'b0;
    bw_settings = 16'hA53C;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h000, 32'h0);
    rdchk(12'h004, 32'h8000);
    rdchk(12'h008, 32'h0);
    rdchk(12'h00C, 32'hF);
    xfer(1'b1, 12'h004, 32'hFFFF);
    rdchk(12'h004, 32'hF000);
    rdchk(12'h01C, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("registers test done");
    ref_present <= 4'hC;
    settle();
    xfer(1'b1, 12'h008, 32'h10);
    settle();
    rdchk(12'h00C, 32'h183);
    xfer(1'b1, 12'h008, 32'h14);
    ref_present <= 4'hD;
    settle();
    rdchk(12'h00C, 32'h182);
    other_ranks <= 6'h04;
    settle();
    rdchk(12'h00C, 32'h102);
    xfer(1'b1, 12'h000, 32'h31);
    settle();
    rdchk(12'h00C, 32'h1C3);
    rdchk(12'h000, 32'h31);
    other_ranks <= 6'h24;
    xfer(1'b1, 12'h000, 32'h30);
    settle();
    rdchk(12'h00C, 32'h182);
    xfer(1'b1, 12'h008, 32'h10);
    xfer(1'b1, 12'h000, 32'h00);
    settle();
    rdchk(12'h00C, 32'h182);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 12'h008, sel_v[i]);
      settle();
      rdchk(12'h00C, sts_v[i]);
    end
    $display("selection test done");
    lock_detect <= 1'b1;
    settle();
    check({31'h0, locked}, 32'h1);
    sync_chk(1'b0);
    xfer(1'b1, 12'h004, 32'h0);
    sync_chk(1'b1);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        src = 2'(s);
        c = k[0];
        bandwidth_pin <= (src == 2'h1) ? c : ~c;
        sm_wants_tracking <= src[0] ? ~c : c;
        xfer(1'b1, 12'h004, {17'h0, (src == 2'h3) ? c : ~c, src, 12'h000});
        repeat (2) @(posedge pclk);
        check({24'h0, bw_shift, bw_mult}, c ? 32'h3C : 32'hA5);
      end
    end
    $display("lock and bandwidth test done");
    xfer(1'b1, 12'h014, 32'h7);
    c = irq;
    xfer(1'b1, 12'h014, 32'h0);
    check({31'h0, c ^ irq}, 32'h1);
    xfer(1'b0, 12'h010, 32'h0);
    check(rd & 32'h1, 32'h1);
    xfer(1'b1, 12'h010, 32'h7);
    rdchk(12'h010, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    print_verdict();
  end
endmodule : tb_dpll_ref_priority_bw_mode
bind ref_rank_bw_ctrl ref_rank_bw_asserts #(.EVAL_CYCLES(EVAL_CYCLES)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .ref_qualified(ref_qualified),
  .bandwidth_pin(bandwidth_pin), .divider_sync(divider_sync), .lock_detect(lock_detect),
  .sm_wants_tracking(sm_wants_tracking), .bw_settings(bw_settings),
  .selected_ref(selected_ref), .ref_valid(ref_valid), .ref_invalid_sts(ref_invalid_sts),
  .locked(locked), .bw_shift(bw_shift), .bw_mult(bw_mult));
